// File: logic/ttx_pkg.sv
// Package of constants and types for the teletext line inserter.
package ttx_pkg;

   // ****************************************************************
   // Clock rates and time figures.
   // ****************************************************************
   localparam int unsigned CLK_HZ  = 100_000_000; // Core clock.
   localparam int unsigned SYS_HZ  = 27_000_000;  // Video tick rate.
   localparam int unsigned T_OUT_NS = 10_200;     // 10.2 us.
   // Ticks from sync edge to first inserted bit, rounded down.
   localparam int unsigned T_OUT_TICKS =
      (T_OUT_NS * (SYS_HZ / 1000)) / 1_000_000;
   localparam int unsigned REQ_SPAN = 16;  // Request lead, ticks.
   localparam int unsigned REQ_BASE = T_OUT_TICKS - REQ_SPAN;

   // ****************************************************************
   // Bit pattern figures.
   // ****************************************************************
   localparam int unsigned LINE_BITS   = 360;
   localparam int unsigned GROUP_BITS  = 37;
   localparam int unsigned GROUP_TICKS = 144;
   localparam int unsigned SHORT_EVERY = 9;
   localparam int unsigned LONG_TICKS  = 4;
   localparam int unsigned SHORT_TICKS = 3;
   localparam int unsigned REM_BITS    = LINE_BITS % GROUP_BITS;
   // Full-line window length in ticks.
   localparam int unsigned WIN_TICKS =
      (LINE_BITS / GROUP_BITS) * GROUP_TICKS + REM_BITS * LONG_TICKS
      - (REM_BITS - 1) / SHORT_EVERY;

   // ****************************************************************
   // Register map and fields.
   // ****************************************************************
   localparam logic [7:0] ADR_SETUP0   = 8'h0e;
   localparam logic [7:0] ADR_SETUP3   = 8'h11;
   localparam logic [7:0] ADR_MODE3    = 8'h12;
   localparam logic [7:0] ADR_REQ_EDGE = 8'h24;
   localparam logic [7:0] ADR_STATUS   = 8'h25;
   localparam int unsigned EN_BIT      = 4;  // Insert enable.
   localparam int unsigned RISE_LSB    = 4;
   localparam int unsigned FALL_LSB    = 0;
   localparam logic [7:0] RST_REG      = 8'h00;
   localparam logic [7:0] LUMA_LO      = 8'h10;
   localparam logic [7:0] LUMA_HI      = 8'hc0;
   localparam logic [7:0] LUMA_MID     = 8'h68;

   // Register port request.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ttx_reg_req_t;

   // Line state, one-hot.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LINE = 3'b010,
      ST_DONE = 3'b100
   } ttx_line_st_t;

   // Tick length of the bit at a position within its group.
   // Three bits wide so that a four-tick bit does not wrap to zero.
   function automatic logic [2:0] bit_len(input logic [5:0] pos);
      bit_len = (pos != 6'h00 && (pos % SHORT_EVERY) == 0) ?
         3'(SHORT_TICKS) : 3'(LONG_TICKS);
   endfunction

endpackage

// File: logic/ttx_tick_gen.sv
// Fractional divider making the video tick enable from the core clock.
`timescale 1ns/1ps
`default_nettype none
module ttx_tick_gen #(
   parameter int unsigned CLK_HZ  = 100_000_000,
   parameter int unsigned TICK_HZ = 27_000_000
) (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   output logic      tick_o
);
   initial begin
      if (TICK_HZ * 2 > CLK_HZ) $error("tick rate too high");
   end

   // Phase accumulator; ticks never fall on two cycles in a row.
   logic [31:0] acc_q;
   logic [31:0] sum;
   assign sum    = acc_q + TICK_HZ;
   assign tick_o = (sum >= CLK_HZ) && !rst_i;

   // Average rate is exact, jitter is one core cycle.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) acc_q <= 32'h0;
      else acc_q <= (sum >= CLK_HZ) ? sum - CLK_HZ : sum;
   end
endmodule
`default_nettype wire

// File: logic/ttx_bit_seq.sv
// Bit duration sequencer for the inserted teletext line.
`timescale 1ns/1ps
`default_nettype none
module ttx_bit_seq
   import ttx_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic tick_i,
   input  wire logic start_i,
   input  wire logic abort_i,
   output logic      bit_start_o,
   output logic      busy_o,
   output logic      done_o
);
   logic       busy_q;  // Line in progress.
   logic [5:0] pos_q;   // Position within group.
   logic [1:0] sub_q;   // Ticks spent in bit.
   logic [8:0] idx_q;   // Bit index in line.
   logic       last, first;
   assign last  = busy_q && tick_i && (sub_q == 2'(bit_len(pos_q) - 3'h1));
   assign first = start_i && tick_i && !busy_q;
   assign done_o = last && idx_q == 9'(LINE_BITS - 1);
   assign bit_start_o = first || (last && !done_o);
   assign busy_o = busy_q;

   // Advance on ticks; short bits every ninth position.
   always_ff @(posedge core_clk_i) begin
      if (rst_i || abort_i) begin
         busy_q <= 1'b0;
         pos_q  <= 6'h0;
         sub_q  <= 2'h0;
         idx_q  <= 9'h0;
      end else if (first) begin
         busy_q <= 1'b1;
         pos_q  <= 6'h0;
         sub_q  <= 2'h0;
         idx_q  <= 9'h0;
      end else if (done_o) begin
         busy_q <= 1'b0;
      end else if (last) begin
         sub_q <= 2'h0;
         idx_q <= idx_q + 9'h1;
         // Group of 37 wraps and repeats.
         pos_q <= (pos_q == 6'(GROUP_BITS - 1)) ? 6'h0 : pos_q + 6'h1;
      end else if (busy_q && tick_i) begin
         sub_q <= sub_q + 2'h1;
      end
   end

   // Helper tick counts for the checks below.
   logic [7:0]  grp_n_q;
   logic [2:0]  bit_n_q;
   logic [11:0] line_n_q;
   always_ff @(posedge core_clk_i) begin
      if (rst_i || first) begin
         grp_n_q <= 8'h1;
         bit_n_q <= 3'h1;
         line_n_q <= 12'h0;
      end else if (tick_i) begin
         grp_n_q <= (bit_start_o && pos_q == 6'(GROUP_BITS - 1)) ?
                    8'h1 : grp_n_q + 8'h1;
         bit_n_q <= bit_start_o ? 3'h1 : bit_n_q + 3'h1;
         line_n_q <= busy_q ? line_n_q + 12'h1 : line_n_q;
      end
   end

   property p_group_ticks;
      @(posedge core_clk_i) disable iff (rst_i || abort_i)
      bit_start_o && busy_q && pos_q == 6'(GROUP_BITS - 1)
         |-> grp_n_q == 8'(GROUP_TICKS);
   endproperty
   a_group_ticks: assert property (p_group_ticks)
      else $error("group of 37 bits not 144 ticks");

   property p_bit_len;
      @(posedge core_clk_i) disable iff (rst_i || abort_i)
      bit_start_o && busy_q |-> bit_n_q == bit_len(pos_q);
   endproperty
   a_bit_len: assert property (p_bit_len)
      else $error("bit duration wrong");

   property p_line_len;
      @(posedge core_clk_i) disable iff (rst_i || abort_i)
      done_o |-> line_n_q == 12'(WIN_TICKS - 1);
   endproperty
   a_line_len: assert property (p_line_len)
      else $error("line not 360 bits long");
endmodule
`default_nettype wire

// File: logic/ttx_vbi_inserter.sv
// Teletext insertion: request pulse, bit sampling and luma levels.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Request rise delayed 0..15 by upper field.
// - Request fall delayed 0..15 by lower field.
// - Larger fall delay shortens the request window.
// - Rise change alone keeps request width constant.
// - Data appears 10.2 us after sync.
// - Fall field zero gives full 360-bit window.
// - Enable low: no request, no insertion.
// - 37 bits span exactly 144 ticks.
// - Bits 10,19,28,37 take three ticks.
// - Pattern repeats until 360 bits done.
// - Bits resampled to bandlimited luma levels.
// - Per-line setup bits enable each line.
// - A one switches that field line on.
module ttx_vbi_inserter
   import ttx_pkg::*;
(
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   input  wire ttx_pkg::ttx_reg_req_t reg_req_i,
   output logic [7:0]                 reg_rdata_o,
   input  wire logic                  hsync_lead_i,
   input  wire logic                  field_odd_i,
   input  wire logic                  vbi_line_valid_i,
   input  wire logic [3:0]            vbi_line_idx_i,
   input  wire logic                  teletext_serial_in_i,
   output logic                       teletext_request_o,
   output logic [7:0]                 ttx_luma_o,
   output logic                       insert_active_o
);
   import ttx_pkg::*;

   // ****************************************************************
   // Register file.
   // ****************************************************************

   logic [3:0][7:0] setup_q;     // Per-line enables, 32 lines.
   logic [7:0]      mode3_q;     // Mode byte with insert enable.
   logic [7:0]      req_edge_q;  // Request edge delays.
   logic [7:0]      rdata_q;     // Read data, one cycle late.
   logic [7:0]      rd_mux;      // Selected read value.
   logic [7:0]      status;      // Live block state.
   logic            sel_setup;   // Address hits a setup byte.
   logic [1:0]      setup_idx;   // Which setup byte.
   logic            teletext_insert_enable;

   assign sel_setup = reg_req_i.addr >= ADR_SETUP0 &&
                      reg_req_i.addr <= ADR_SETUP3;
   assign setup_idx = 2'(reg_req_i.addr - ADR_SETUP0);
   assign teletext_insert_enable = mode3_q[EN_BIT];

   // Writes store in one cycle; the slave never stalls.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         setup_q    <= {4{RST_REG}};
         mode3_q    <= RST_REG;
         req_edge_q <= RST_REG;
      end else if (reg_req_i.wr) begin
         if (sel_setup) setup_q[setup_idx] <= reg_req_i.wdata;
         if (reg_req_i.addr == ADR_MODE3) mode3_q <= reg_req_i.wdata;
         if (reg_req_i.addr == ADR_REQ_EDGE)
            req_edge_q <= reg_req_i.wdata;
      end
   end

   // Unmapped reads return zero; status is read only.
   assign rd_mux =
      sel_setup                         ? setup_q[setup_idx] :
      (reg_req_i.addr == ADR_MODE3)     ? mode3_q :
      (reg_req_i.addr == ADR_REQ_EDGE)  ? req_edge_q :
      (reg_req_i.addr == ADR_STATUS)    ? status : 8'h00;

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) rdata_q <= 8'h00;
      else rdata_q <= reg_req_i.rd ? rd_mux : 8'h00;
   end
   assign reg_rdata_o = rdata_q;

   // ****************************************************************
   // Video tick and line position.
   // ****************************************************************

   logic        tick;        // 27 MHz enable.
   logic [11:0] tick_cnt_q;  // Ticks since sync leading edge.

   ttx_tick_gen #(
      .CLK_HZ  (CLK_HZ),
      .TICK_HZ (SYS_HZ)
   ) u_tick (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .tick_o     (tick)
   );

   // Count restarts on each sync edge and stops at full scale.
   always_ff @(posedge core_clk_i) begin
      if (rst_i || hsync_lead_i) tick_cnt_q <= 12'h000;
      else if (tick && tick_cnt_q != 12'hfff)
         tick_cnt_q <= tick_cnt_q + 12'h001;
   end

   // ****************************************************************
   // Line selection and state.
   // ****************************************************************

   ttx_line_st_t st_q;        // Line state.
   ttx_line_st_t st_d;        // Next line state.
   logic [31:0]  setup_vec;   // All setup bits flat.
   logic [4:0]   line_sel;    // Odd field first two bytes.
   logic         line_on;     // This line carries teletext.
   logic         seq_done;    // Last bit finished.
   logic         seq_busy;    // Bits are being placed.
   logic         seq_bit;     // First tick of a bit.
   logic         seq_start;   // Start the sequencer.

   assign setup_vec = setup_q;
   assign line_sel  = {~field_odd_i, vbi_line_idx_i};
   // Setup bit one switches the line on.
   assign line_on   = teletext_insert_enable && vbi_line_valid_i &&
                      setup_vec[line_sel];

   // Next-state choice; disabling closes the window at once.
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (hsync_lead_i && line_on) st_d = ST_LINE;
         end
         ST_LINE: begin
            if (hsync_lead_i) st_d = line_on ? ST_LINE : ST_IDLE;
            else if (seq_done) st_d = ST_DONE;
         end
         ST_DONE: begin
            if (hsync_lead_i) st_d = line_on ? ST_LINE : ST_IDLE;
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
      // Enable low forces the window shut.
      if (!teletext_insert_enable) st_d = ST_IDLE;
   end

   // State register.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) st_q <= ST_IDLE;
      else st_q <= st_d;
   end

   // ****************************************************************
   // Request pulse.
   // ****************************************************************

   logic [3:0]  rise_q;    // Rise delay held for the line.
   logic [3:0]  fall_q;    // Fall delay held for the line.
   logic [11:0] rise_at;   // Tick count of rising edge.
   logic [11:0] fall_at;   // Tick count of falling edge.
   logic        req_d;     // Request next value.
   logic        req_q;     // Request pin register.
   logic        in_line;   // Line state active.

   // Delays are latched per line so a mid-line write cannot
   // tear the pulse; they take effect on the next line.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rise_q <= 4'h0;
         fall_q <= 4'h0;
      end else if (hsync_lead_i) begin
         rise_q <= req_edge_q[RISE_LSB +: 4];
         fall_q <= req_edge_q[FALL_LSB +: 4];
      end
   end

   // Both edges measured from the sync reference.
   assign rise_at = 12'(REQ_BASE) + {8'h00, rise_q};
   // Fall tracks rise, minus its own delay.
   // A zero fall delay keeps the full line width.
   assign fall_at = rise_at + 12'(WIN_TICKS) - {8'h00, fall_q};
   assign in_line = (st_q == ST_LINE);
   // Larger fall delay ends the window sooner.
   assign req_d = in_line && teletext_insert_enable &&
                  tick_cnt_q >= rise_at && tick_cnt_q < fall_at;

   // Request comes straight from a flip-flop.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) req_q <= 1'b0;
      else req_q <= req_d;
   end
   assign teletext_request_o = req_q;

   // ****************************************************************
   // Bit sequencing and resampling.
   // ****************************************************************

   // First bit lands on the tick that reaches the output time.
   assign seq_start = in_line && teletext_insert_enable &&
                      tick_cnt_q == 12'(T_OUT_TICKS - 1);

   ttx_bit_seq u_seq (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .tick_i      (tick),
      .start_i     (seq_start),
      .abort_i     (!in_line),
      .bit_start_o (seq_bit),
      .busy_o      (seq_busy),
      .done_o      (seq_done)
   );

   logic       bit_q;     // Current teletext bit.
   logic [7:0] luma_q;    // Output level register.
   logic       act_q;     // Insertion active flag.
   logic       changed;   // New bit differs from old.

   assign changed = teletext_serial_in_i != bit_q;

   // The source was asked early enough that its bits sit on the
   // input at these instants; only enabled lines are sampled.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) bit_q <= 1'b0;
      else if (seq_bit) bit_q <= teletext_serial_in_i;
   end

   // Edges get one mid-level tick, a two-phase interpolation
   // that halves the step and hides the 3/4 tick jitter.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         luma_q <= LUMA_LO;
      end else if (tick) begin
         if (seq_bit && changed) luma_q <= LUMA_MID;
         else if (seq_bit) luma_q <= bit_q ? LUMA_HI : LUMA_LO;
         else if (seq_busy) luma_q <= bit_q ? LUMA_HI : LUMA_LO;
         else luma_q <= LUMA_LO;
      end
   end
   assign ttx_luma_o = luma_q;

   // Active flag follows the sequencer.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) act_q <= 1'b0;
      else act_q <= seq_busy && in_line;
   end
   assign insert_active_o = act_q;

   assign status = {5'h00, act_q, req_q, in_line};

   // ****************************************************************
   // Checks.
   // ****************************************************************

   logic [11:0] width_q;   // Ticks with request high.
   always_ff @(posedge core_clk_i) begin
      if (rst_i || !req_q) width_q <= 12'h000;
      else if (tick) width_q <= width_q + 12'h001;
   end

   property p_req_rise;
      @(posedge core_clk_i) disable iff (rst_i)
      $rose(req_q) |-> $past(tick_cnt_q) == rise_at;
   endproperty
   a_req_rise: assert property (p_req_rise)
      else $error("request rose at wrong tick");

   property p_req_fall;
      @(posedge core_clk_i) disable iff (rst_i)
      $fell(req_q) && $past(in_line && teletext_insert_enable) &&
         $past(tick_cnt_q) != 12'h0 |-> $past(tick_cnt_q) == fall_at;
   endproperty
   a_req_fall: assert property (p_req_fall)
      else $error("request fell at wrong tick");

   property p_req_width;
      @(posedge core_clk_i) disable iff (rst_i)
      $fell(req_q) && $past(in_line) && $past(tick_cnt_q) == fall_at
         |-> $past(width_q) == 12'(WIN_TICKS) - {8'h00, fall_q};
   endproperty
   a_req_width: assert property (p_req_width)
      else $error("request width not window minus fall delay");

   property p_disabled;
      @(posedge core_clk_i) disable iff (rst_i)
      !teletext_insert_enable |-> ##2 !req_q && !act_q;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("request or insertion while disabled");

   property p_out_time;
      @(posedge core_clk_i) disable iff (rst_i)
      $rose(seq_busy) |-> tick_cnt_q == 12'(T_OUT_TICKS);
   endproperty
   a_out_time: assert property (p_out_time)
      else $error("insertion did not start at 10.2 us");

   sequence s_line_hit;
      hsync_lead_i && line_on;
   endsequence
   property p_line_on;
      @(posedge core_clk_i) disable iff (rst_i)
      s_line_hit |=> in_line;
   endproperty
   a_line_on: assert property (p_line_on)
      else $error("enabled line not opened");

   property p_line_off;
      @(posedge core_clk_i) disable iff (rst_i)
      hsync_lead_i && teletext_insert_enable &&
         !setup_vec[line_sel] |=> !in_line ##1 !req_q;
   endproperty
   a_line_off: assert property (p_line_off)
      else $error("line without setup bit opened");

   property p_interp;
      @(posedge core_clk_i) disable iff (rst_i)
      tick && seq_bit && changed |=> luma_q == LUMA_MID;
   endproperty
   a_interp: assert property (p_interp)
      else $error("bit edge not interpolated");

endmodule
`default_nettype wire

// File: testbench/ttx_src_model.sv
// Behavioural teletext source answering the request line.
`timescale 1ns/1ps
`default_nettype none
module ttx_src_model (
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       req_i,
   input  wire logic       level_i,
   input  wire logic [5:0] delay_i,
   output logic            serial_o
);
   logic [63:0] pipe_q; // Request as seen through the source pipeline.

   // Shift the request so data can be timed to any pipeline depth from 1 to 64 cycles.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pipe_q <= '0;
      end else begin
         pipe_q <= {pipe_q[62:0], req_i};
      end
   end

   // Gated off, the line shows the inverse level, never stale data.
   assign serial_o = pipe_q[delay_i] ? level_i : ~level_i;
endmodule
`default_nettype wire

// File: testbench/ttx_vbi_inserter_test.sv
// Self-checking bench of the teletext line inserter.
`timescale 1ns/1ps
`default_nettype none
module ttx_vbi_inserter_test;
   import ttx_pkg::*;
   logic         core_clk_i = 1'b0; // Core clock.
   logic         rst_i      = 1'b1; // Synchronous reset.
   ttx_reg_req_t req        = '0;   // Register port request.
   logic         hsync      = 1'b0; // Line reference pulse.
   logic         fodd       = 1'b1; // Field flag.
   logic         lvalid     = 1'b1; // Line is a VBI line.
   logic [3:0]   lidx       = 4'h0; // VBI line index.
   logic         lvl        = 1'b1; // Level the source sends.
   logic [5:0]   dly        = 6'h00; // Source pipeline depth.
   logic [7:0]   rdata, luma;
   logic         ser, treq, act;
   logic [7:0]   regs [6] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h24};
   int           mismatches = 0, samples_checked = 0, seed = 22;
   int           t_rise, t_fall, t_on, t_off, n_off;

   ttx_vbi_inserter u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .reg_req_i(req), .reg_rdata_o(rdata), .hsync_lead_i(hsync),
      .field_odd_i(fodd), .vbi_line_valid_i(lvalid),
      .vbi_line_idx_i(lidx), .teletext_serial_in_i(ser),
      .teletext_request_o(treq), .ttx_luma_o(luma),
      .insert_active_o(act));
   ttx_src_model u_src (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .req_i(treq), .level_i(lvl), .delay_i(dly), .serial_o(ser));

   always #5 core_clk_i = ~core_clk_i;

   // ****************************************************************
   // Helpers.
   // ****************************************************************
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, lo, hi, input string what);
      samples_checked++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("MISMATCH %0t %s %0d out of %0d..%0d", $time, what,
            got, lo, hi);
      end
   endtask

   // Core cycles spanned by a count of video ticks.
   function automatic int cyc(input int ticks);
      return (ticks * 100) / 27;
   endfunction

   // Ticks taken by the first bits of a line, bit lengths built up.
   function automatic int span(input int nbits);
      int s = 0;
      for (int b = 0; b < nbits; b++) begin
         s += (b % 37 % 9 == 0 && b % 37 != 0) ? 3 : 4;
      end
      return s;
   endfunction

   // Setup register holding the enable of a field line.
   function automatic logic [7:0] sadr(input logic f, input logic [3:0] k);
      return ADR_SETUP0 + {6'h00, ~f, k[3]};
   endfunction

   task automatic wr(input logic [7:0] a, d);
      @(posedge core_clk_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk_i);
      req <= '0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd_chk(input logic [7:0] a, exp);
      @(posedge core_clk_i);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk_i);
      req <= '0;
      #1 chk8(rdata, exp, "read");
   endtask

   // One line: times are cycles after the edge that takes the pulse.
   task automatic run_line(input logic on, input int rise, fall);
      int sp;
      t_rise = -1; t_fall = -1; t_on = -1; t_off = -1; n_off = 0;
      sp = span(360);
      @(posedge core_clk_i);
      hsync <= 1'b1;
      dly <= 6'(cyc(14 - rise));
      @(posedge core_clk_i);
      hsync <= 1'b0;
      for (int i = 1; i < 6400; i++) begin
         #1;
         if (treq === 1'b1 && t_rise < 0) t_rise = i;
         if (treq !== 1'b1 && t_rise >= 0 && t_fall < 0) t_fall = i;
         if (act === 1'b1 && t_on < 0) t_on = i;
         if (act !== 1'b1 && t_on >= 0 && t_off < 0) t_off = i;
         if (act === 1'b1 && luma !== (lvl ? LUMA_HI : LUMA_LO)) n_off++;
         if (!on && luma !== LUMA_LO) n_off++;
         @(posedge core_clk_i);
      end
      if (!on) begin
         chk_rng(t_rise + t_on + n_off, -2, -2, "closed line");
      end else begin
         chk_rng(t_rise, cyc(259 + rise) - 3, cyc(259 + rise) + 6,
            "rise");
         chk_rng(t_fall - t_rise, cyc(sp - fall) - 5, cyc(sp - fall) + 5,
            "width");
         chk_rng(t_on, cyc(275) - 3, cyc(275) + 6, "out");
         chk_rng(t_off - t_on, cyc(sp) - 5, cyc(sp) + 5,
            "span");
         chk_rng(span(37), 144, 144, "group");
         if (fall == 0) chk_rng(n_off, 0, 8, "full");
         if (fall >= 6) chk_rng(n_off, 3 * (fall - 4), 6400,
            "short");
      end
   endtask

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      int rise, fall, w0;
      logic f;
      logic [3:0] k;
      repeat (16) @(posedge core_clk_i);
      rst_i <= 1'b0;
      foreach (regs[j]) rd_chk(regs[j], RST_REG);
      foreach (regs[j]) begin
         k = 4'($random(seed));
         wr(regs[j], {k, ~k});
         rd_chk(regs[j], {k, ~k});
      end
      wr(8'h30, 8'h5a);
      rd_chk(8'h30, 8'h00);
      wr(ADR_STATUS, 8'hff);
      rd_chk(ADR_STATUS, 8'h00);
      // Every line allowed, but the enable is low: nothing may open.
      for (int j = 0; j < 4; j++) wr(regs[j], 8'hff);
      wr(ADR_MODE3, 8'h00);
      run_line(1'b0, 0, 0);
      for (int j = 0; j < 4; j++) wr(regs[j], 8'h00);
      wr(ADR_MODE3, 8'(1 << EN_BIT));
      for (int n = 0; n < 4; n++) begin
         rise = (n == 2) ? 0 : {$random(seed)} % 14;
         fall = (n == 2) ? 15 : (n < 2) ? 0 : {$random(seed)} % 16;
         {f, k} = 5'($random(seed));
         fodd <= f;
         lidx <= k;
         lvl <= 1'($random(seed));
         wr(ADR_REQ_EDGE, {4'(rise), 4'(fall)});
         wr(sadr(f, k), 8'h01 << k[2:0]);
         run_line(1'b1, rise, fall);
         if (n == 1) chk_rng(t_fall - t_rise - w0, -5, 5, "kept");
         w0 = t_fall - t_rise;
         if (n < 3) wr(sadr(f, k), 8'h00);
      end
      // Neighbour line and other field of the enabled line stay closed.
      lidx <= k ^ 4'h1;
      run_line(1'b0, 0, 0);
      fodd <= ~f;
      lidx <= k;
      run_line(1'b0, 0, 0);
      // A line outside the blanking interval never opens.
      fodd <= f;
      lvalid <= 1'b0;
      run_line(1'b0, 0, 0);
      lvalid <= 1'b1;
      // Enable dropped mid-line must close the window at once.
      @(posedge core_clk_i);
      hsync <= 1'b1;
      @(posedge core_clk_i);
      hsync <= 1'b0;
      repeat (2000) @(posedge core_clk_i);
      #1 chk8({6'h00, treq, act}, 8'h03, "open");
      // Status shows line, request and insertion all live.
      rd_chk(ADR_STATUS, 8'h07);
      wr(ADR_MODE3, 8'h00);
      repeat (3) @(posedge core_clk_i);
      #1 chk8({6'h00, treq, act}, 8'h00, "closed late");
      end_sim();
   end

   // A hang is cut short well after the last line should have ended.
   initial begin
      #700_000;
      mismatches++;
      end_sim();
   end
endmodule
`default_nettype wire
